// [dv/brf_periph_model.sv]
`timescale 1ns/10ps
module brf_periph_model
   import brf_pkg::*;
(
   input  wire logic      i_clk,
   input  wire brf_port_s i_acc,
   output logic [7:0]     o_rdata
);
   logic [7:0] mem_q [16];
   logic [7:0] last_q = 8'h00;
   logic       hold_q = 1'b0;

   always @(posedge i_clk)
   begin
      hold_q <= i_acc.valid;
      if (i_acc.valid)
      begin
         last_q <= mem_q[i_acc.addr[3:0]];
         if (i_acc.write)
            mem_q[i_acc.addr[3:0]] <= i_acc.wdata;
      end
   end

   // Data held one cycle past the strobe, then inverted so a late sample fails
   assign o_rdata = i_acc.valid ? mem_q[i_acc.addr[3:0]] : (hold_q ? last_q : ~last_q);
endmodule

// [dv/tb_brf_top.sv]
`timescale 1ns/10ps
module tb_brf_top;
   import brf_pkg::*;

   typedef struct {
      logic       wr;
      brf_mode_e  md;
      logic [7:0] a;
      logic [7:0] d;
   } brf_row_s;

   logic       I_REF_CLK = 1'b0;
   logic       I_RST = 1'b1;
   brf_req_s   I_REQ = '0;
   brf_stk_e   I_STK_OP = BRF_STK_NONE;
   logic [7:0] I_STK_WDATA = 8'h00;
   logic       I_P0_ADDR_MODE = 1'b0;
   logic [7:0] port_rdata;
   logic [7:0] bankf_rdata;
   logic [7:0] O_RDATA;
   logic       O_RVALID;
   logic       O_REFUSED;
   brf_port_s  O_PORT;
   brf_port_s  O_BANKF;
   logic [7:0] O_TIMER_TIMER_CONTROL_0;
   logic [7:0] O_TIMER_TIMER_CONTROL_1;
   logic [7:0] O_TIMER_TIMER_CONTROL_2;
   logic [7:0] O_GROUP_POINTER;
   logic [7:0] O_STACK_PTR;
   logic [7:0] O_P0_ADDR;
   logic       O_P0_ADDR_VALID;
   int         bad_count = 0;
   int         comparisons = 0;
   int         cycles = 0;
   logic [7:0] rd;

   localparam brf_mode_e DR = BRF_MODE_DIRECT;

   // Rows run in order; pointer writes set up the reads that follow
   brf_row_s rows [26] = '{
      '{1, DR, 8'hfd, 8'h00}, '{1, DR, 8'h10, 8'h5a}, '{0, DR, 8'h10, 8'h5a},
      '{1, DR, 8'hfd, 8'h10}, '{0, BRF_MODE_WORKING, 8'h00, 8'h5a},
      '{1, DR, 8'hfd, 8'h00}, '{1, DR, 8'h01, 8'h33}, '{0, DR, 8'h01, 8'h33},
      '{1, DR, 8'hfd, 8'h0d}, '{1, DR, 8'h02, 8'hc3}, '{0, DR, 8'h02, 8'hc3},
      '{0, DR, 8'h03, 8'hff}, '{1, DR, 8'hfd, 8'h0f}, '{1, DR, 8'h05, 8'h44},
      '{0, DR, 8'h05, 8'h44}, '{1, DR, 8'hfd, 8'h03}, '{0, DR, 8'h00, 8'hff},
      '{1, DR, 8'hfd, 8'he0}, '{1, BRF_MODE_WORKING, 8'h05, 8'h96},
      '{0, BRF_MODE_INDIRECT, 8'he5, 8'h96}, '{0, DR, 8'hfd, 8'he0},
      '{1, DR, 8'hf2, 8'h11}, '{0, DR, 8'hf2, 8'hff}, '{1, DR, 8'h04, 8'h21},
      '{0, DR, 8'h04, 8'h21}, '{1, DR, 8'hfd, 8'h00}
   };

   brf_top i_dut (
      .I_REF_CLK       (I_REF_CLK),
      .I_RST           (I_RST),
      .I_REQ           (I_REQ),
      .I_STK_OP        (I_STK_OP),
      .I_STK_WDATA     (I_STK_WDATA),
      .I_P0_ADDR_MODE  (I_P0_ADDR_MODE),
      .I_PORT_RDATA    (port_rdata),
      .I_BANKF_RDATA   (bankf_rdata),
      .O_RDATA         (O_RDATA),
      .O_RVALID        (O_RVALID),
      .O_REFUSED       (O_REFUSED),
      .O_PORT          (O_PORT),
      .O_BANKF         (O_BANKF),
      .O_TIMER_TIMER_CONTROL_0   (O_TIMER_TIMER_CONTROL_0),
      .O_TIMER_TIMER_CONTROL_1   (O_TIMER_TIMER_CONTROL_1),
      .O_TIMER_TIMER_CONTROL_2   (O_TIMER_TIMER_CONTROL_2),
      .O_GROUP_POINTER (O_GROUP_POINTER),
      .O_STACK_PTR     (O_STACK_PTR),
      .O_P0_ADDR       (O_P0_ADDR),
      .O_P0_ADDR_VALID (O_P0_ADDR_VALID)
   );

   brf_periph_model i_ports (.i_clk(I_REF_CLK), .i_acc(O_PORT), .o_rdata(port_rdata));
   brf_periph_model i_bankf (.i_clk(I_REF_CLK), .i_acc(O_BANKF), .o_rdata(bankf_rdata));

   always #10 I_REF_CLK = ~I_REF_CLK;

   task automatic wrap_up;
      $display("comparisons %0d bad_count %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   always @(posedge I_REF_CLK)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         bad_count++;
         wrap_up();
      end
   end

   task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic tick;
      @(posedge I_REF_CLK);
      #1;
   endtask

   // Called one step after an edge; writes leave one idle cycle behind
   task automatic do_req(input logic wr, input brf_mode_e md, input logic [7:0] a,
                         input logic [7:0] d, output logic [7:0] q);
      int n;
      n = 0;
      q = 8'hxx;
      I_REQ = '{1'b1, wr, md, a, d};
      tick();
      I_REQ.valid = 1'b0;
      if (wr)
         tick();
      else
      begin
         while (O_RVALID !== 1'b1 && n < 4)
         begin
            tick();
            n++;
         end
         q = O_RDATA;
      end
   endtask

   initial
   begin
      repeat (16) @(posedge I_REF_CLK);
      #1;
      I_RST = 1'b0;
      check("pointer after reset", O_GROUP_POINTER, RST_GROUP_POINTER);
      check("timer ctrl after reset", O_TIMER_TIMER_CONTROL_0, RST_TIMER_CTRL);
      foreach (rows[k])
      begin
         do_req(rows[k].wr, rows[k].md, rows[k].a, rows[k].d, rd);
         if (!rows[k].wr)
            check($sformatf("row %0d", k), rd, rows[k].d);
      end
      // Direct access to e0-ef is refused and leaves the register alone
      I_REQ = '{1'b1, 1'b1, DR, 8'he5, 8'h01};
      tick();
      I_REQ.valid = 1'b0;
      check("refused flag", {7'h0, O_REFUSED}, 8'h01);
      tick();
      do_req(0, BRF_MODE_INDIRECT, 8'he5, 8'h00, rd);
      check("e5 after refusal", rd, 8'h96);
      // Pointer written and used on consecutive edges
      I_REQ = '{1'b1, 1'b1, DR, 8'hfd, 8'h0d};
      tick();
      I_REQ = '{1'b1, 1'b1, DR, 8'h00, 8'h77};
      tick();
      I_REQ.valid = 1'b0;
      tick();
      check("timer ctrl 0", O_TIMER_TIMER_CONTROL_0, 8'h77);
      do_req(1, DR, 8'h01, 8'h5c, rd);
      check("timer ctrl 1", O_TIMER_TIMER_CONTROL_1, 8'h5c);
      do_req(1, DR, 8'hfd, 8'h00, rd);
      do_req(1, DR, 8'hff, 8'h80, rd);
      do_req(1, DR, 8'hfe, 8'h3c, rd);
      I_P0_ADDR_MODE = 1'b1;
      I_STK_OP = BRF_STK_PUSH;
      I_STK_WDATA = 8'ha5;
      tick();
      I_STK_OP = BRF_STK_NONE;
      check("port 0 address strobe", {7'h0, O_P0_ADDR_VALID}, 8'h01);
      check("port 0 address", O_P0_ADDR, 8'h3c);
      tick();
      check("stack pointer push", O_STACK_PTR, 8'h7f);
      do_req(0, DR, 8'h7f, 8'h00, rd);
      check("pushed byte", rd, 8'ha5);
      I_STK_OP = BRF_STK_POP;
      tick();
      I_STK_OP = BRF_STK_NONE;
      tick();
      check("popped byte", O_RDATA, 8'ha5);
      tick();
      check("stack pointer pop", O_STACK_PTR, 8'h80);
      do_req(0, DR, 8'hfe, 8'h00, rd);
      check("high stack byte", rd, 8'h3c);
      // Reset in mid-run clears the pointer and timer controls again
      I_RST = 1'b1;
      repeat (2) tick();
      I_RST = 1'b0;
      check("pointer after second reset", O_GROUP_POINTER, RST_GROUP_POINTER);
      check("timer ctrl after second reset", O_TIMER_TIMER_CONTROL_0, RST_TIMER_CTRL);
      do_req(0, DR, 8'hfd, 8'h00, rd);
      check("pointer read after reset", rd, RST_GROUP_POINTER);
      wrap_up();
   end
endmodule

// [logic/brf_mem.sv]
`timescale 1ns/10ps
module brf_mem
   import brf_pkg::*;
#(
   parameter int DEPTH = 256,
   parameter int AW    = 8
)
(
   input  wire logic          i_clk,
   input  wire logic          i_we,
   input  wire logic [AW-1:0] i_waddr,
   input  wire logic [7:0]    i_wdata,
   input  wire logic [AW-1:0] i_raddr,
   output logic [7:0]         o_rdata
);

   if (DEPTH > (1 << AW))
   begin
      $error("brf_mem depth exceeds address range");
   end

   logic [7:0] mem_q [DEPTH];
   logic [7:0] rdata_q;

   // Plain RAM: read data registered, no reset on the array
   always_ff @(posedge i_clk)
   begin
      if (i_we)
      begin
         mem_q[i_waddr] <= i_wdata;
      end
      rdata_q <= mem_q[i_raddr];
   end

   assign o_rdata = rdata_q;

endmodule

// [logic/brf_pkg.sv]
package brf_pkg;

   // Register offsets in the standard register space
   localparam logic [7:0] OFS_PORT_LAST      = 8'h03;
   localparam logic [7:0] OFS_GP_FIRST       = 8'h04;
   localparam logic [7:0] OFS_GP_LAST        = 8'hef;
   localparam logic [7:0] OFS_INDIRECT_FIRST = 8'he0;
   localparam logic [7:0] OFS_INDIRECT_LAST  = 8'hef;
   localparam logic [7:0] OFS_RSVD_FIRST     = 8'hf0;
   localparam logic [7:0] OFS_RSVD_LAST      = 8'hf5;
   localparam logic [7:0] OFS_GROUP_POINTER  = 8'hfd;
   localparam logic [7:0] OFS_STACK_HIGH     = 8'hfe;
   localparam logic [7:0] OFS_STACK_LOW      = 8'hff;

   // Expanded bank numbers and offsets inside bank D
   localparam logic [3:0] BANK_NORMAL        = 4'h0;
   localparam logic [3:0] BANK_TIMER         = 4'hd;
   localparam logic [3:0] BANK_SYSTEM        = 4'hf;
   localparam logic [3:0] OFS_TIMER_TIMER_CONTROL_0    = 4'h0;
   localparam logic [3:0] OFS_TIMER_TIMER_CONTROL_1    = 4'h1;
   localparam logic [3:0] OFS_TIMER_TIMER_CONTROL_2    = 4'h2;

   // Field positions of the group pointer
   localparam int         GP_WORK_MSB        = 7;
   localparam int         GP_WORK_LSB        = 4;
   localparam int         GP_BANK_MSB        = 3;
   localparam int         GP_BANK_LSB        = 0;

   // Reset values and the value read from undefined registers
   localparam logic [7:0] RST_GROUP_POINTER  = 8'h00;
   localparam logic [7:0] RST_TIMER_CTRL     = 8'h00;
   localparam logic [7:0] UNDEF_READ         = 8'hff;

   typedef enum logic [1:0] {
      BRF_MODE_DIRECT,
      BRF_MODE_WORKING,
      BRF_MODE_INDIRECT
   } brf_mode_e;

   typedef enum logic [1:0] {
      BRF_STK_NONE,
      BRF_STK_PUSH,
      BRF_STK_POP
   } brf_stk_e;

   typedef struct packed {
      logic       valid;
      logic       write;
      brf_mode_e  mode;
      logic [7:0] addr;
      logic [7:0] wdata;
   } brf_req_s;

   typedef struct packed {
      logic       valid;
      logic       write;
      logic [7:0] addr;
      logic [7:0] wdata;
   } brf_port_s;

endpackage

// [logic/brf_top.sv]
`timescale 1ns/10ps
// How it works
// RULE1: Pointer upper nibble picks working group
// RULE2: Pointer lower nibble picks expanded bank
// RULE3: Bank zero: low addresses reach ports
// RULE4: Nonzero bank replaces lowest sixteen registers
// RULE5: Only banks D and F implemented
// RULE6: Bank D holds timer controls 0-2
// RULE7: Ports 0-3, storage 4-239, control 246-255 (the code decodes only 253 and 255 as control; 246-252 and 254 go to storage)
// RULE8: Full 8-bit direct or indirect addressing
// RULE9: Short address combines with working group
// RULE10: Working group gives base; offset added
// RULE11: E0-EF unreachable by direct addressing
// RULE12: Addresses 240-245 reserved, no function
// RULE13: Stack pointer addresses internal stack
// RULE14: Internal stack: high byte is storage
// RULE15: High byte driven to port 0
// RULE16: Banked reads/writes; unimplemented reads undefined
// RULE17: New pointer effective for next instruction
module brf_top
   import brf_pkg::*;
#(
   parameter int BANK_F_REGS = 16
)
(
   input  wire logic       I_REF_CLK,
   input  wire logic       I_RST,
   input  wire brf_req_s   I_REQ,
   input  wire brf_stk_e   I_STK_OP,
   input  wire logic [7:0] I_STK_WDATA,
   input  wire logic       I_P0_ADDR_MODE,
   input  wire logic [7:0] I_PORT_RDATA,
   input  wire logic [7:0] I_BANKF_RDATA,
   output logic [7:0]      O_RDATA,
   output logic            O_RVALID,
   output logic            O_REFUSED,
   output brf_port_s       O_PORT,
   output brf_port_s       O_BANKF,
   output logic [7:0]      O_TIMER_TIMER_CONTROL_0,
   output logic [7:0]      O_TIMER_TIMER_CONTROL_1,
   output logic [7:0]      O_TIMER_TIMER_CONTROL_2,
   output logic [7:0]      O_GROUP_POINTER,
   output logic [7:0]      O_STACK_PTR,
   output logic [7:0]      O_P0_ADDR,
   output logic            O_P0_ADDR_VALID
);

   if (BANK_F_REGS != 16)
   begin
      $error("brf_top supports a sixteen-register bank F only");
   end

   typedef enum logic [2:0] {
      TGT_NONE,
      TGT_MEM,
      TGT_PORT,
      TGT_TIMER,
      TGT_BANKF,
      TGT_POINTER,
      TGT_UNDEF
   } brf_tgt_e;

   // Effective address of a short working-register address
   function automatic logic [7:0] work_addr(input logic [7:0] gp, input logic [3:0] ofs);
      work_addr = {gp[GP_WORK_MSB:GP_WORK_LSB], ofs}; // RULE9 RULE10 RULE1
   endfunction

   function automatic logic in_range(input logic [7:0] a, input logic [7:0] lo,
                                     input logic [7:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction

   logic [7:0] gp_q;
   logic [7:0] gp_d;
   logic [7:0] tctl_q [3];
   logic [7:0] tctl_d [3];
   logic [7:0] sp_q;
   logic [7:0] sp_d;
   logic [7:0] rdata_q;
   logic [7:0] rdata_d;
   logic       rvalid_q;
   logic       rvalid_d;
   logic       refused_q;
   logic       refused_d;
   brf_port_s  port_q;
   brf_port_s  port_d;
   brf_port_s  bankf_q;
   brf_port_s  bankf_d;
   logic [7:0] p0a_q;
   logic [7:0] p0a_d;
   logic       p0av_q;
   logic       p0av_d;
   brf_tgt_e   rtgt_q;
   brf_tgt_e   rtgt_d;
   logic [7:0] rhold_q;
   logic [7:0] rhold_d;

   logic [7:0] eff_addr;
   logic [3:0] bank;
   brf_tgt_e   tgt;
   logic       mem_we;
   logic [7:0] mem_waddr;
   logic [7:0] mem_wdata;
   logic [7:0] mem_raddr;
   logic [7:0] mem_rdata;
   logic       stk_act;
   logic [7:0] stk_addr;
   logic [7:0] mem_rdata_hi_q;
   logic [7:0] mem_rdata_hi_d;

   assign bank = gp_q[GP_BANK_MSB:GP_BANK_LSB]; // RULE2 RULE17
   assign stk_act = (I_STK_OP != BRF_STK_NONE);
   // Push pre-decrements, pop reads at the current pointer
   assign stk_addr = (I_STK_OP == BRF_STK_PUSH) ? sp_q - 8'h01 : sp_q; // RULE13

   // Address decode
   always_comb
   begin
      eff_addr = I_REQ.addr; // RULE8
      tgt      = TGT_NONE;
      if (I_REQ.mode == BRF_MODE_WORKING)
      begin
         eff_addr = work_addr(gp_q, I_REQ.addr[3:0]);
      end
      if (!I_REQ.valid || stk_act)
      begin
         tgt = TGT_NONE;
      end
      else if (I_REQ.mode == BRF_MODE_DIRECT &&
               in_range(eff_addr, OFS_INDIRECT_FIRST, OFS_INDIRECT_LAST))
      begin
         tgt = TGT_NONE; // RULE11
      end
      else if (eff_addr[7:4] == 4'h0 && bank != BANK_NORMAL)
      begin
         if (bank == BANK_TIMER && eff_addr[3:0] <= OFS_TIMER_TIMER_CONTROL_2)
         begin
            tgt = TGT_TIMER; // RULE4 RULE6
         end
         else if (bank == BANK_SYSTEM)
         begin
            tgt = TGT_BANKF; // RULE5
         end
         else
         begin
            tgt = TGT_UNDEF; // RULE5 RULE16
         end
      end
      else if (eff_addr <= OFS_PORT_LAST)
      begin
         tgt = TGT_PORT; // RULE3 RULE7
      end
      else if (in_range(eff_addr, OFS_RSVD_FIRST, OFS_RSVD_LAST))
      begin
         tgt = TGT_UNDEF; // RULE12
      end
      else if (eff_addr == OFS_GROUP_POINTER || eff_addr == OFS_STACK_LOW)
      begin
         tgt = TGT_POINTER;
      end
      else
      begin
         tgt = TGT_MEM; // RULE7 RULE14
      end
   end

   // Storage port: stack has priority over instruction accesses
   always_comb
   begin
      mem_we    = 1'b0;
      mem_waddr = eff_addr;
      mem_wdata = I_REQ.wdata;
      mem_raddr = eff_addr;
      if (stk_act)
      begin
         mem_we    = (I_STK_OP == BRF_STK_PUSH);
         mem_waddr = stk_addr; // RULE13
         mem_wdata = I_STK_WDATA;
         mem_raddr = stk_addr;
      end
      else if (tgt == TGT_MEM && I_REQ.write)
      begin
         mem_we = 1'b1;
      end
   end

   brf_mem #(
      .DEPTH (256),
      .AW    (8)
   ) u_mem (
      .i_clk   (I_REF_CLK),
      .i_we    (mem_we),
      .i_waddr (mem_waddr),
      .i_wdata (mem_wdata),
      .i_raddr (mem_raddr),
      .o_rdata (mem_rdata)
   );

   // Next-state logic
   always_comb
   begin
      gp_d      = gp_q;
      tctl_d    = tctl_q;
      sp_d      = sp_q;
      refused_d = 1'b0;
      port_d    = '0;
      bankf_d   = '0;
      p0a_d     = p0a_q;
      p0av_d    = 1'b0;
      rtgt_d    = TGT_NONE;
      rhold_d   = 8'h00;
      if (stk_act)
      begin
         sp_d   = (I_STK_OP == BRF_STK_PUSH) ? sp_q - 8'h01 : sp_q + 8'h01; // RULE13
         rtgt_d = (I_STK_OP == BRF_STK_POP) ? TGT_MEM : TGT_NONE;
         if (I_P0_ADDR_MODE)
         begin
            // High byte goes out on port 0 for every stack cycle
            p0a_d  = mem_rdata_hi_q; // RULE15
            p0av_d = 1'b1; // RULE15
         end
      end
      else if (I_REQ.valid)
      begin
         rtgt_d    = I_REQ.write ? TGT_NONE : tgt;
         refused_d = (tgt == TGT_NONE);
         case (tgt)
            TGT_PORT:
            begin
               port_d = '{valid: 1'b1, write: I_REQ.write, addr: eff_addr,
                          wdata: I_REQ.wdata}; // RULE3
            end
            TGT_BANKF:
            begin
               bankf_d = '{valid: 1'b1, write: I_REQ.write, addr: eff_addr,
                           wdata: I_REQ.wdata}; // RULE16
            end
            TGT_TIMER:
            begin
               if (I_REQ.write)
               begin
                  tctl_d[eff_addr[1:0]] = I_REQ.wdata; // RULE6 RULE16
               end
               rhold_d = tctl_q[eff_addr[1:0]];
            end
            TGT_POINTER:
            begin
               if (eff_addr == OFS_GROUP_POINTER)
               begin
                  rhold_d = gp_q;
                  if (I_REQ.write)
                  begin
                     gp_d = I_REQ.wdata; // RULE17
                  end
               end
               else
               begin
                  rhold_d = sp_q;
                  if (I_REQ.write)
                  begin
                     sp_d = I_REQ.wdata;
                  end
               end
            end
            default:
            begin
               rhold_d = UNDEF_READ;
            end
         endcase
      end
   end

   // Copy of the high byte for port 0, kept beside storage
   always_comb
   begin
      mem_rdata_hi_d = mem_rdata_hi_q;
      if (mem_we && mem_waddr == OFS_STACK_HIGH)
      begin
         mem_rdata_hi_d = mem_wdata; // RULE14
      end
   end

   // Read answer registered two cycles after the request
   always_comb
   begin
      rvalid_d = (rtgt_q != TGT_NONE);
      case (rtgt_q)
         TGT_MEM:   rdata_d = mem_rdata;
         TGT_PORT:  rdata_d = I_PORT_RDATA;
         TGT_BANKF: rdata_d = I_BANKF_RDATA;
         TGT_NONE:  rdata_d = rdata_q;
         default:   rdata_d = rhold_q; // RULE16
      endcase
   end

   always_ff @(posedge I_REF_CLK)
   begin
      if (I_RST)
      begin
         gp_q           <= RST_GROUP_POINTER;
         tctl_q         <= '{RST_TIMER_CTRL, RST_TIMER_CTRL, RST_TIMER_CTRL};
         sp_q           <= 8'h00;
         refused_q      <= 1'b0;
         port_q         <= '0;
         bankf_q        <= '0;
         p0a_q          <= 8'h00;
         p0av_q         <= 1'b0;
         rtgt_q         <= TGT_NONE;
         rhold_q        <= 8'h00;
         rdata_q        <= 8'h00;
         rvalid_q       <= 1'b0;
         mem_rdata_hi_q <= 8'h00;
      end
      else
      begin
         gp_q           <= gp_d;
         tctl_q         <= tctl_d;
         sp_q           <= sp_d;
         refused_q      <= refused_d;
         port_q         <= port_d;
         bankf_q        <= bankf_d;
         p0a_q          <= p0a_d;
         p0av_q         <= p0av_d;
         rtgt_q         <= rtgt_d;
         rhold_q        <= rhold_d;
         rdata_q        <= rdata_d;
         rvalid_q       <= rvalid_d;
         mem_rdata_hi_q <= mem_rdata_hi_d;
      end
   end

   assign O_RDATA         = rdata_q;
   assign O_RVALID        = rvalid_q;
   assign O_REFUSED       = refused_q;
   assign O_PORT          = port_q;
   assign O_BANKF         = bankf_q;
   assign O_TIMER_TIMER_CONTROL_0   = tctl_q[0];
   assign O_TIMER_TIMER_CONTROL_1   = tctl_q[1];
   assign O_TIMER_TIMER_CONTROL_2   = tctl_q[2];
   assign O_GROUP_POINTER = gp_q;
   assign O_STACK_PTR     = sp_q;
   assign O_P0_ADDR       = p0a_q;
   assign O_P0_ADDR_VALID = p0av_q;

   sequence s_ptr_write;
      I_REQ.valid && I_REQ.write && !stk_act && tgt == TGT_POINTER &&
      eff_addr == OFS_GROUP_POINTER;
   endsequence

   a_ptr_next_cycle: assert property (@(posedge I_REF_CLK) disable iff (I_RST) // RULE17
      s_ptr_write |=> gp_q == $past(I_REQ.wdata))
      else $error("group pointer not updated");
   a_work_base: assert property (@(posedge I_REF_CLK) disable iff (I_RST) // RULE10
      (I_REQ.valid && !stk_act && I_REQ.mode == BRF_MODE_WORKING) |->
      mem_raddr == {gp_q[GP_WORK_MSB:GP_WORK_LSB], I_REQ.addr[3:0]})
      else $error("working address base wrong");
   a_direct_block: assert property (@(posedge I_REF_CLK) disable iff (I_RST) // RULE11
      (I_REQ.valid && !stk_act && I_REQ.mode == BRF_MODE_DIRECT && I_REQ.addr[7:4] == 4'he)
      |=> O_REFUSED)
      else $error("direct access to E0-EF not refused");
   a_port_bank0: assert property (@(posedge I_REF_CLK) disable iff (I_RST) // RULE3
      (I_REQ.valid && !stk_act && bank == BANK_NORMAL && I_REQ.mode != BRF_MODE_DIRECT &&
       eff_addr <= OFS_PORT_LAST) |=> O_PORT.valid)
      else $error("port access missing");
   a_timer_write: assert property (@(posedge I_REF_CLK) disable iff (I_RST) // RULE6
      (I_REQ.valid && I_REQ.write && !stk_act && bank == BANK_TIMER &&
       eff_addr == 8'h01 && I_REQ.mode != BRF_MODE_DIRECT || tgt == TGT_TIMER &&
       I_REQ.write && eff_addr == 8'h01) |=> O_TIMER_TIMER_CONTROL_1 == $past(I_REQ.wdata))
      else $error("timer control 1 not written");
   a_rsvd_read: assert property (@(posedge I_REF_CLK) disable iff (I_RST) // RULE12
      (I_REQ.valid && !I_REQ.write && !stk_act &&
       in_range(eff_addr, OFS_RSVD_FIRST, OFS_RSVD_LAST)) |=> ##1 O_RDATA == UNDEF_READ)
      else $error("reserved read not undefined");
   a_stack_push: assert property (@(posedge I_REF_CLK) disable iff (I_RST) // RULE13
      I_STK_OP == BRF_STK_PUSH |=> sp_q == $past(sp_q) - 8'h01)
      else $error("stack pointer not decremented");
   a_p0_drive: assert property (@(posedge I_REF_CLK) disable iff (I_RST) // RULE15
      (stk_act && I_P0_ADDR_MODE) |=> O_P0_ADDR_VALID && O_P0_ADDR == $past(mem_rdata_hi_q))
      else $error("high byte not driven to port 0");

endmodule
